// ==== common/lcli_defs.svh ====
// Constants for the logging cycle LED indicator: offsets of time, voltage levels and widths.
`ifndef LCLI_DEFS_SVH
`define LCLI_DEFS_SVH

`define LCLI_CLK_HZ           64'd100000000
`define LCLI_TMR_W            36
`define LCLI_VAL_W            16
`define LCLI_VOLT_W           8
`define LCLI_FLASH_W          3
`define LCLI_DUTY_W           8

`define LCLI_FEATURE_LVL      49
`define LCLI_SEQ_MIN_FEATURE  26
`define LCLI_FADE_MIN_FEATURE 49

`define LCLI_BOOT_S           64'd3
`define LCLI_BOOT_CYC         (`LCLI_BOOT_S * `LCLI_CLK_HZ)
`define LCLI_ACQ_TYP_S        64'd8
`define LCLI_ACQ_MAX_S        64'd300
`define LCLI_ACQ_MAX_CYC      (`LCLI_ACQ_MAX_S * `LCLI_CLK_HZ)
`define LCLI_FADE_S           64'd1
`define LCLI_FADE_CYC         (`LCLI_FADE_S * `LCLI_CLK_HZ)
`define LCLI_FADE_STEPS       64'd256
`define LCLI_SOLID_S          64'd3
`define LCLI_SOLID_CYC        (`LCLI_SOLID_S * `LCLI_CLK_HZ)
`define LCLI_FLASH_ON_MS      64'd100
`define LCLI_FLASH_OFF_MS     64'd200
`define LCLI_FLASH_GAP_MS     64'd500
`define LCLI_FLASH_ON_CYC     (`LCLI_FLASH_ON_MS * `LCLI_CLK_HZ / 64'd1000)
`define LCLI_FLASH_OFF_CYC    (`LCLI_FLASH_OFF_MS * `LCLI_CLK_HZ / 64'd1000)
`define LCLI_FLASH_GAP_CYC    (`LCLI_FLASH_GAP_MS * `LCLI_CLK_HZ / 64'd1000)

// Battery levels in tenths of a volt.
`define LCLI_V_4V9            8'h31
`define LCLI_V_4V8            8'h30
`define LCLI_V_4V6            8'h2E
`define LCLI_V_4V4            8'h2C
`define LCLI_V_4V2            8'h2A

`endif

// ==== common/lcli_pkg.sv ====
// Types shared by the logging cycle LED indicator modules.
`include "lcli_defs.svh"

package lcli_pkg;

	typedef enum logic [3:0] {
		ST_OFF, ST_BOOT, ST_ACQ, ST_FLASH, ST_GAP, ST_SLEEP, ST_WAKE, ST_HOLD
	} lcli_state_e;

	typedef enum logic [1:0] {
		FL_IDLE, FL_ON, FL_OFF
	} lcli_flash_e;

	typedef struct packed {
		logic                     valid;
		logic [`LCLI_VAL_W-1:0]   value;
	} lcli_reading_s;

	typedef struct packed {
		logic                     store;
		logic [`LCLI_VAL_W-1:0]   value;
		logic [`LCLI_VOLT_W-1:0]  batt;
	} lcli_record_s;

endpackage

// ==== design/lcli_flash_gen.sv ====
// Flash train generator: emits a given number of short LED flashes.
`include "lcli_defs.svh"

module lcli_flash_gen
	import lcli_pkg::*;
#(
	parameter logic [31:0] ON_CYC  = 32'(`LCLI_FLASH_ON_CYC),
	parameter logic [31:0] OFF_CYC = 32'(`LCLI_FLASH_OFF_CYC)
) (
	input  wire logic                    core_clk_i,
	input  wire logic                    nrst_i,
	input  wire logic                    start_i,
	input  wire logic [`LCLI_FLASH_W-1:0] count_i,
	output logic                         led_o,
	output logic                         done_o
);

	lcli_flash_e              state_reg;
	logic [31:0]              tmr_reg;
	logic [`LCLI_FLASH_W-1:0] left_reg;
	logic                     done_reg;

	////////////////////////////////////////////////////////////////////////////////

	// Each flash is followed by its off time, which also spaces the flashes apart.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= FL_IDLE;
			tmr_reg   <= 32'h0;
			left_reg  <= '0;
			done_reg  <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			unique case (state_reg)
				FL_IDLE: begin
					if (start_i && count_i != '0) begin
						state_reg <= FL_ON;
						tmr_reg   <= ON_CYC - 32'h1;
						left_reg  <= count_i;
					end else if (start_i) begin
						done_reg <= 1'b1;
					end
				end
				FL_ON: begin
					if (tmr_reg == 32'h0) begin
						state_reg <= FL_OFF;
						tmr_reg   <= OFF_CYC - 32'h1;
						left_reg  <= left_reg - `LCLI_FLASH_W'(1);
					end else begin
						tmr_reg <= tmr_reg - 32'h1;
					end
				end
				FL_OFF: begin
					if (tmr_reg != 32'h0) begin
						tmr_reg <= tmr_reg - 32'h1;
					end else if (left_reg == '0) begin
						state_reg <= FL_IDLE;
						done_reg  <= 1'b1;
					end else begin
						state_reg <= FL_ON;
						tmr_reg   <= ON_CYC - 32'h1;
					end
				end
			endcase
		end
	end

	assign led_o  = (state_reg == FL_ON);
	assign done_o = done_reg;

endmodule

// ==== design/lcli_top.sv ====
// Battery-mode status LED and logging cycle sequencer.
//
// Summary of operation
// - The LED sequence runs only while on battery supply and only from feature level 26 on.
// - At power-up the LED stays lit for three seconds while the sensor is powered and updates are accepted.
// - A record is stored only when the minute is scheduled and the reading passes the threshold.
// - A reading typically takes about 8 s and is abandoned after 300 s without a valid result.
// - A battery voltage above 4.9 V gives exactly one short flash at shutdown.
// - Lower battery gives 2 to 5 flashes at the 4.8, 4.6, 4.4 and 4.2 V levels, and 6 flashes below 4.2 V.
// - The battery voltage is sampled at the end of the reading, while the load is still on.
// - The device wakes at each minute boundary that arrives while it sleeps to check for a due record, then flashes again.
// - On wake the LED fades from full to off within one second, or is solid for 3 s below level 49.
// - A measurement is made even when the threshold would suppress the record.
`include "lcli_defs.svh"

module lcli_top
	import lcli_pkg::*;
#(
	parameter int                     FEATURE_LEVEL   = `LCLI_FEATURE_LVL,
	parameter logic [`LCLI_TMR_W-1:0] BOOT_CYC        = `LCLI_TMR_W'(`LCLI_BOOT_CYC),
	parameter logic [`LCLI_TMR_W-1:0] ACQ_TIMEOUT_CYC = `LCLI_TMR_W'(`LCLI_ACQ_MAX_CYC),
	parameter logic [`LCLI_TMR_W-1:0] FADE_CYC        = `LCLI_TMR_W'(`LCLI_FADE_CYC),
	parameter logic [`LCLI_TMR_W-1:0] SOLID_CYC       = `LCLI_TMR_W'(`LCLI_SOLID_CYC),
	parameter logic [31:0]            FLASH_ON_CYC    = 32'(`LCLI_FLASH_ON_CYC),
	parameter logic [31:0]            FLASH_OFF_CYC   = 32'(`LCLI_FLASH_OFF_CYC),
	parameter logic [`LCLI_TMR_W-1:0] FLASH_GAP_CYC   = `LCLI_TMR_W'(`LCLI_FLASH_GAP_CYC)
) (
	input  wire logic                     core_clk_i,
	input  wire logic                     nrst_i,
	input  wire logic                     battery_mode_i,
	input  wire logic                     minute_tick_i,
	input  wire logic                     scheduled_i,
	input  wire logic [`LCLI_VAL_W-1:0]   threshold_i,
	input  wire lcli_reading_s            reading_i,
	input  wire logic [`LCLI_VOLT_W-1:0]  batt_level_i,
	output logic                          led_o,
	output logic                          sensor_pwr_o,
	output logic                          fw_update_en_o,
	output logic                          acq_req_o,
	output logic                          acq_timeout_o,
	output lcli_record_s                  record_o
);

	// The fade walks the duty cycle down in equal steps; rounding down keeps it inside one second.
	localparam logic [`LCLI_TMR_W-1:0] FADE_STEP_CYC =
		`LCLI_TMR_W'(FADE_CYC / `LCLI_TMR_W'(`LCLI_FADE_STEPS));
	localparam logic SEQ_ENABLED = (FEATURE_LEVEL >= `LCLI_SEQ_MIN_FEATURE);
	localparam logic FADE_WAKE   = (FEATURE_LEVEL >= `LCLI_FADE_MIN_FEATURE);

	lcli_state_e              state_reg;
	lcli_state_e              state_next;
	logic [`LCLI_TMR_W-1:0]   tmr_reg;
	logic [1:0]               pin_meta_reg;
	logic [1:0]               pin_sync_reg;
	logic                     tick_d_reg;
	logic                     minute_rise;
	logic                     on_battery;
	logic                     acq_end;
	logic [`LCLI_FLASH_W-1:0] flash_cnt_reg;
	logic [`LCLI_FLASH_W-1:0] flash_cnt_next;
	logic                     flash_start_reg;
	logic                     flash_led;
	logic                     flash_done;
	logic [`LCLI_DUTY_W-1:0]  duty_reg;
	logic [`LCLI_DUTY_W-1:0]  pwm_cnt_reg;
	logic                     led_reg;
	logic                     led_next;
	logic                     timeout_reg;
	lcli_record_s             record_reg;

	////////////////////////////////////////////////////////////////////////////////

	// Battery-present and minute tick arrive from outside the clock domain.
	wire logic [1:0] pin_raw = {minute_tick_i, battery_mode_i};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sync
			always_ff @(posedge core_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					pin_meta_reg[g] <= 1'b0;
					pin_sync_reg[g] <= 1'b0;
				end else begin
					pin_meta_reg[g] <= pin_raw[g];
					pin_sync_reg[g] <= pin_meta_reg[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tick_d_reg <= 1'b0;
		end else begin
			tick_d_reg <= pin_sync_reg[1];
		end
	end

	assign on_battery  = pin_sync_reg[0] && SEQ_ENABLED;
	assign minute_rise = pin_sync_reg[1] && !tick_d_reg;

	// A reading ends on a valid result or when the wait runs out.
	assign acq_end = (state_reg == ST_ACQ) && (reading_i.valid || tmr_reg == '0);

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		state_next = state_reg;
		if (!on_battery) begin
			state_next = ST_OFF;
		end else begin
			unique case (state_reg)
				ST_OFF:   state_next = ST_BOOT;
				ST_BOOT:  if (tmr_reg == '0) state_next = ST_ACQ;
				ST_ACQ:   if (acq_end) state_next = ST_FLASH;
				ST_FLASH: if (flash_done) state_next = ST_GAP;
				ST_GAP:   if (tmr_reg == '0) state_next = ST_SLEEP;
				ST_SLEEP: if (minute_rise) state_next = FADE_WAKE ? ST_WAKE : ST_HOLD;
				ST_WAKE: begin
					if (duty_reg == '0 && tmr_reg == '0) begin
						state_next = scheduled_i ? ST_ACQ : ST_FLASH;
					end
				end
				ST_HOLD: begin
					if (tmr_reg == '0) begin
						state_next = scheduled_i ? ST_ACQ : ST_FLASH;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// One timer serves every timed phase but the flash train, which the flash generator times, and is reloaded on entry.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tmr_reg <= '0;
		end else if (state_next != state_reg) begin
			unique case (state_next)
				ST_BOOT: tmr_reg <= BOOT_CYC - `LCLI_TMR_W'(1);
				ST_ACQ:  tmr_reg <= ACQ_TIMEOUT_CYC - `LCLI_TMR_W'(1);
				ST_GAP:  tmr_reg <= FLASH_GAP_CYC - `LCLI_TMR_W'(1);
				ST_WAKE: tmr_reg <= FADE_STEP_CYC - `LCLI_TMR_W'(1);
				ST_HOLD: tmr_reg <= SOLID_CYC - `LCLI_TMR_W'(1);
				default: tmr_reg <= '0;
			endcase
		end else if (state_reg == ST_WAKE && tmr_reg == '0) begin
			tmr_reg <= FADE_STEP_CYC - `LCLI_TMR_W'(1);
		end else if (tmr_reg != '0) begin
			tmr_reg <= tmr_reg - `LCLI_TMR_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Flash count from the battery level; a level between marks takes the lower mark.
	always_comb begin
		if (batt_level_i > `LCLI_V_4V9) begin
			flash_cnt_next = `LCLI_FLASH_W'(1);
		end else if (batt_level_i >= `LCLI_V_4V8) begin
			flash_cnt_next = `LCLI_FLASH_W'(2);
		end else if (batt_level_i >= `LCLI_V_4V6) begin
			flash_cnt_next = `LCLI_FLASH_W'(3);
		end else if (batt_level_i >= `LCLI_V_4V4) begin
			flash_cnt_next = `LCLI_FLASH_W'(4);
		end else if (batt_level_i >= `LCLI_V_4V2) begin
			flash_cnt_next = `LCLI_FLASH_W'(5);
		end else begin
			flash_cnt_next = `LCLI_FLASH_W'(6);
		end
	end

	// Sampling at the end of the reading catches the sag under measurement load.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flash_cnt_reg <= `LCLI_FLASH_W'(1);
		end else if (acq_end) begin
			flash_cnt_reg <= flash_cnt_next;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			record_reg  <= '0;
			timeout_reg <= 1'b0;
		end else begin
			record_reg.store <= 1'b0;
			timeout_reg      <= acq_end && !reading_i.valid;
			if (acq_end) begin
				record_reg.value <= reading_i.value;
				record_reg.batt  <= batt_level_i;
				record_reg.store <= reading_i.valid && scheduled_i
					&& (reading_i.value > threshold_i);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flash_start_reg <= 1'b0;
		end else begin
			flash_start_reg <= (state_next == ST_FLASH) && (state_reg != ST_FLASH);
		end
	end

	lcli_flash_gen #(
		.ON_CYC  (FLASH_ON_CYC),
		.OFF_CYC (FLASH_OFF_CYC)
	) u_flash (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.start_i    (flash_start_reg),
		.count_i    (flash_cnt_reg),
		.led_o      (flash_led),
		.done_o     (flash_done)
	);

	// The fade is a PWM whose duty drops one step per step period.
	// Restarting the PWM count on wake makes the first period open at full brightness.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pwm_cnt_reg <= '0;
			duty_reg    <= '0;
		end else if (state_next == ST_WAKE && state_reg != ST_WAKE) begin
			pwm_cnt_reg <= '0;
			duty_reg    <= '1;
		end else begin
			pwm_cnt_reg <= pwm_cnt_reg + `LCLI_DUTY_W'(1);
			if (state_reg == ST_WAKE && tmr_reg == '0 && duty_reg != '0) begin
				duty_reg <= duty_reg - `LCLI_DUTY_W'(1);
			end
		end
	end

	always_comb begin
		unique case (state_reg)
			ST_BOOT:  led_next = 1'b1;
			ST_HOLD:  led_next = 1'b1;
			ST_WAKE:  led_next = (pwm_cnt_reg < duty_reg);
			ST_FLASH: led_next = flash_led;
			default:  led_next = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			led_reg <= 1'b0;
		end else begin
			led_reg <= led_next;
		end
	end

	assign led_o          = led_reg;
	assign sensor_pwr_o   = (state_reg == ST_BOOT) || (state_reg == ST_ACQ);
	assign fw_update_en_o = (state_reg == ST_BOOT);
	assign acq_req_o      = (state_reg == ST_ACQ);
	assign acq_timeout_o  = timeout_reg;
	assign record_o       = record_reg;

endmodule

// ==== verification/lcli_sensor_model.sv ====
// Behavioural light sensor path and battery monitor facing the indicator.
module lcli_sensor_model
	import lcli_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        acq_req_i,
	input  wire logic [15:0] dly_i,
	input  wire logic [15:0] val_i,
	input  wire logic [7:0]  batt_i,
	output lcli_reading_s    reading_o,
	output logic [7:0]       batt_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] cnt_reg;

	initial begin
		cnt_reg   = '0;
		reading_o = '0;
		batt_o    = '0;
	end

	// Outside a reading the sensor value is stale and the unloaded battery reads differently,
	// so both lines show junk there and a late sample is caught.
	always @(negedge core_clk_i) begin
		cnt_reg         <= acq_req_i ? cnt_reg + 16'h0001 : 16'h0000;
		reading_o.valid <= acq_req_i && (cnt_reg == dly_i);
		reading_o.value <= (acq_req_i && cnt_reg == dly_i) ? val_i : ~reading_o.value;
		batt_o          <= acq_req_i ? batt_i : ~batt_i;
	end
endmodule

// ==== verification/lcli_top_assertions.sv ====
// Port-level assertions for the logging cycle LED indicator.
`include "lcli_defs.svh"

module lcli_top_chk
	import lcli_pkg::*;
#(
	parameter logic [`LCLI_TMR_W-1:0] BOOT_CYC        = 36'h32,
	parameter logic [`LCLI_TMR_W-1:0] ACQ_TIMEOUT_CYC = 36'hC8
) (
	input wire logic                    core_clk_i,
	input wire logic                    nrst_i,
	input wire logic                    battery_mode_i,
	input wire logic                    scheduled_i,
	input wire logic [`LCLI_VAL_W-1:0]  threshold_i,
	input wire lcli_reading_s           reading_i,
	input wire logic [`LCLI_VOLT_W-1:0] batt_level_i,
	input wire logic                    led_o,
	input wire logic                    sensor_pwr_o,
	input wire logic                    fw_update_en_o,
	input wire logic                    acq_req_o,
	input wire logic                    acq_timeout_o,
	input wire lcli_record_s            record_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);

	////////////////////////////////////////////////////////////////////////////////
	// Run lengths are counted here because repetitions of fifty or more cycles are too costly.
	logic [`LCLI_TMR_W-1:0] boot_cnt_reg;
	logic [`LCLI_TMR_W-1:0] acq_cnt_reg;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			boot_cnt_reg <= '0;
			acq_cnt_reg  <= '0;
		end else begin
			boot_cnt_reg <= fw_update_en_o ? boot_cnt_reg + 1'b1 : '0;
			acq_cnt_reg  <= acq_req_o ? acq_cnt_reg + 1'b1 : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	chk_batt_off: assert property (!battery_mode_i [*5] |-> !led_o && !sensor_pwr_o && !acq_req_o)
		else $error("outputs active without battery supply");
	chk_boot_power: assert property (fw_update_en_o |-> sensor_pwr_o && !acq_req_o)
		else $error("boot phase outputs wrong");
	chk_boot_led: assert property (fw_update_en_o ##1 fw_update_en_o |-> led_o)
		else $error("LED dark during boot");
	chk_boot_len: assert property ($fell(fw_update_en_o) && acq_req_o |-> boot_cnt_reg == BOOT_CYC)
		else $error("boot phase length wrong");
	chk_store_cause: assert property (record_o.store |-> $past(acq_req_o) && $past(reading_i.valid)
		&& $past(scheduled_i) && ($past(reading_i.value) > $past(threshold_i)))
		else $error("record stored without cause");
	chk_store_value: assert property (record_o.store |-> record_o.value == $past(reading_i.value))
		else $error("stored value differs from reading");
	chk_acq_limit: assert property (acq_timeout_o |-> acq_cnt_reg == ACQ_TIMEOUT_CYC && !record_o.store)
		else $error("reading abandoned at wrong time");
	chk_timeout_pulse: assert property (acq_timeout_o |=> !acq_timeout_o)
		else $error("timeout flag longer than one cycle");
	chk_batt_sample: assert property ($fell(acq_req_o) && ($past(reading_i.valid) || acq_timeout_o)
		|-> record_o.batt == $past(batt_level_i))
		else $error("battery not sampled at reading end");

	cover property (record_o.store);
	cover property (acq_timeout_o);
	cover property ($fell(fw_update_en_o));
endmodule

bind lcli_top lcli_top_chk #(.BOOT_CYC(BOOT_CYC), .ACQ_TIMEOUT_CYC(ACQ_TIMEOUT_CYC)) u_chk (
	.core_clk_i(core_clk_i), .nrst_i(nrst_i), .battery_mode_i(battery_mode_i),
	.scheduled_i(scheduled_i), .threshold_i(threshold_i), .reading_i(reading_i),
	.batt_level_i(batt_level_i), .led_o(led_o), .sensor_pwr_o(sensor_pwr_o),
	.fw_update_en_o(fw_update_en_o), .acq_req_o(acq_req_o), .acq_timeout_o(acq_timeout_o),
	.record_o(record_o));

// ==== verification/lcli_top_tb.sv ====
// Self-checking bench for the logging cycle LED indicator.
module lcli_top_tb
	import lcli_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic          core_clk_i, nrst_i, battery_mode_i, minute_tick_i, scheduled_i;
	logic [15:0]   threshold_i, m_dly, m_val;
	logic [7:0]    batt_level_i, m_batt;
	lcli_reading_s reading_i;
	logic          led_o, sensor_pwr_o, fw_update_en_o, acq_req_o, acq_timeout_o;
	lcli_record_s  record_o;
	int            error_cnt, compares;

	// The solid wake hold is unreachable at the default feature level, so its length stays as built.
	lcli_top #(.BOOT_CYC(36'h32), .ACQ_TIMEOUT_CYC(36'hC8), .FADE_CYC(36'h200),
		.FLASH_ON_CYC(32'h4), .FLASH_OFF_CYC(32'h4), .FLASH_GAP_CYC(36'h8)) DUT (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i), .battery_mode_i(battery_mode_i),
		.minute_tick_i(minute_tick_i), .scheduled_i(scheduled_i), .threshold_i(threshold_i),
		.reading_i(reading_i), .batt_level_i(batt_level_i), .led_o(led_o),
		.sensor_pwr_o(sensor_pwr_o), .fw_update_en_o(fw_update_en_o), .acq_req_o(acq_req_o),
		.acq_timeout_o(acq_timeout_o), .record_o(record_o));

	lcli_sensor_model u_model (.core_clk_i(core_clk_i), .acq_req_i(acq_req_o), .dly_i(m_dly),
		.val_i(m_val), .batt_i(m_batt), .reading_o(reading_i), .batt_o(batt_level_i));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [24:0] e, input logic [24:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s: expected %h, seen %h", n, e, g);
		end
	endtask

	task automatic give_verdict();
		if (error_cnt == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic tick();
		minute_tick_i = 1'b1;
		repeat (4) @(negedge core_clk_i);
		minute_tick_i = 1'b0;
	endtask

	// Returns on the cycle after the reading ends, where the record and timeout flag stand.
	task automatic read_cycle(input logic [15:0] v, input logic [7:0] b, input logic [15:0] d,
		output int len);
		m_val = v;
		m_batt = b;
		m_dly = d;
		len = 0;
		for (int i = 0; i < 800 && acq_req_o !== 1'b1; i++) @(negedge core_clk_i);
		for (int i = 0; i < 400 && acq_req_o === 1'b1; i++) begin
			len++;
			@(negedge core_clk_i);
		end
	endtask

	// A flash is a high run of exactly the on-time, which the fade ramp cannot mimic reliably.
	task automatic flashes(input int win, output logic [24:0] n);
		int run;
		n = '0;
		run = 0;
		repeat (win) begin
			@(negedge core_clk_i);
			if (led_o === 1'b1) run++;
			else begin
				if (run == 4) n++;
				run = 0;
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_boot();
		int fw, ld, len;
		logic [24:0] n;
		fw = 0;
		ld = 0;
		repeat (20) @(negedge core_clk_i);
		chk("idle_outputs", 25'h0, {led_o, sensor_pwr_o, acq_req_o});
		m_batt = 8'h32;
		m_dly = 16'h000A;
		battery_mode_i = 1'b1;
		repeat (56) begin
			@(negedge core_clk_i);
			fw += (fw_update_en_o === 1'b1);
			ld += (fw_update_en_o === 1'b1 && led_o === 1'b1);
		end
		chk("boot_len", 25'd50, 25'(fw));
		chk("boot_led", 25'd49, 25'(ld));
		chk("acq_unscheduled", 25'h1, {24'h0, acq_req_o});
		read_cycle(16'h0005, 8'h32, 16'h000A, len);
		chk("record", {1'b0, 16'h0005, 8'h32}, record_o);
		flashes(80, n);
		chk("flashes", 25'd1, n);
	endtask

	task automatic t_table();
		logic [7:0] bv [9] = '{8'h32, 8'h31, 8'h30, 8'h2F, 8'h2E, 8'h2C, 8'h2A, 8'h29, 8'h28};
		int ex [9] = '{1, 2, 2, 3, 3, 4, 5, 6, 6};
		logic [24:0] n;
		int len;
		scheduled_i = 1'b1;
		threshold_i = 16'h0010;
		for (int i = 0; i < 9; i++) begin
			tick();
			read_cycle(16'h0011 + 16'(i), bv[i], 16'h0003, len);
			chk("record", {1'b1, 16'h0011 + 16'(i), bv[i]}, record_o);
			flashes(80, n);
			chk("flashes", 25'(ex[i]), n);
		end
		tick();
		read_cycle(16'h0010, 8'h2D, 16'h0003, len);
		chk("record_at_threshold", {1'b0, 16'h0010, 8'h2D}, record_o);
		flashes(80, n);
		chk("flashes", 25'd4, n);
	endtask

	task automatic t_wake();
		int hi;
		logic [24:0] n;
		hi = 0;
		scheduled_i = 1'b0;
		tick();
		repeat (10) begin
			@(negedge core_clk_i);
			hi += (led_o === 1'b1);
		end
		chk("wake_bright", 25'h1, {24'h0, hi >= 9});
		flashes(700, n);
		chk("wake_flashes", 25'd4, n);
	endtask

	task automatic t_timeout();
		int len;
		logic [24:0] n;
		scheduled_i = 1'b1;
		tick();
		read_cycle(16'h0020, 8'h31, 16'hFFFF, len);
		chk("acq_len", 25'd200, 25'(len));
		chk("timeout_flag", 25'h2, {23'h0, acq_timeout_o, record_o.store});
		chk("timeout_batt", 25'h31, {17'h0, record_o.batt});
		flashes(80, n);
		chk("flashes", 25'd2, n);
	endtask

	task automatic t_batt_off();
		tick();
		for (int i = 0; i < 800 && acq_req_o !== 1'b1; i++) @(negedge core_clk_i);
		battery_mode_i = 1'b0;
		repeat (6) @(negedge core_clk_i);
		chk("off_outputs", 25'h0, {led_o, sensor_pwr_o, acq_req_o, fw_update_en_o});
		tick();
		repeat (100) @(negedge core_clk_i);
		chk("off_after_tick", 25'h0, {led_o, sensor_pwr_o, acq_req_o});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	initial begin
		repeat (30000) @(posedge core_clk_i);
		error_cnt++;
		give_verdict();
	end

	initial begin
		error_cnt = 0;
		compares = 0;
		nrst_i = 1'b0;
		battery_mode_i = 1'b0;
		minute_tick_i = 1'b0;
		scheduled_i = 1'b0;
		threshold_i = 16'h0000;
		m_dly = 16'h000A;
		m_val = 16'h0000;
		m_batt = 8'h32;
		repeat (4) @(negedge core_clk_i);
		nrst_i = 1'b1;
		t_boot();
		t_table();
		t_wake();
		t_timeout();
		t_batt_off();
		give_verdict();
	end
endmodule
